// >>> shared/qls_pkg.sv
/*
 * Package for the quad link status and event flag register bank:
 * register offsets, bit positions, reset values and the source and bus carrier structs.
 * Assumes one clock domain and a plain address/strobe register port.
 */
package qls_pkg;

    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_PAIR_EVT = 8'h83;
    localparam logic [7:0] ADDR_LINK_STS = 8'h84;
    localparam logic [7:0] ADDR_SYNC_EVT = 8'h85;
    localparam logic [7:0] ADDR_PLL_STS = 8'h86;
    localparam logic [7:0] ADDR_RSVD = 8'h87;
    localparam logic [7:0] ADDR_PLL_EVT = 8'h88;

    // -------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------
    localparam int POS_PAIR_LOSS = 0;
    localparam int POS_PAIR_GAIN = 2;
    localparam int POS_PAIR_FAIL = 4;
    localparam int POS_PAIR_MULTI = 6;
    localparam int POS_LINK_INV = 0;
    localparam int POS_LINK_LIVE = 4;
    localparam int POS_SYNC_LOSS = 0;
    localparam int POS_SYNC_GAIN = 4;
    localparam int POS_PLL_LOCK = 4;
    localparam int POS_PLL_LOSS = 7;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [3:0] RST_LINK = 4'h0;
    localparam logic [1:0] RST_PAIR = 2'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [7:0] RD_RSVD = 8'h00;

    // -------------------------------------------------------------
    // carriers of the status sources and of the register port
    // -------------------------------------------------------------
    typedef struct packed {
        logic [1:0] pair_aligned;
        logic [1:0] pair_fail;
        logic [1:0] pair_multi;
        logic [1:0] pair_sm_en;
        logic [3:0] link_up;
        logic pll_lock;
    } qls_src_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
    } qls_bus_t;

endpackage

// >>> rtl/qls_sync.sv
/*
 * Two flop synchroniser, one per bit, for status levels from other logic.
 * Assumes the inputs are quasi static levels from outside mclk_i.
 */
`timescale 1ns/1ps
module qls_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

// >>> rtl/qls_flag.sv
/*
 * Sticky flag bank: set by a pulse, cleared by a clear pulse.
 * Assumes set and clear come from mclk_i logic.
 */
`timescale 1ns/1ps
module qls_flag #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic clr_i,
    output logic [WIDTH-1:0] flag_o
);
    logic [WIDTH-1:0] flag_ff;
    logic [WIDTH-1:0] nxt_flag;

    // set wins so an event in the read cycle survives the read-clear
    assign nxt_flag = set_i | (clr_i ? '0 : flag_ff);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_ff <= qls_pkg::RST_FLAGS[WIDTH-1:0];
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag_o = flag_ff;
endmodule

// >>> rtl/qls_top.sv
/*
 * Quad status and event flag register bank: pair alignment events,
 * word aligner link status with sync events, and PLL lock status and
 * events, read over a plain address/strobe port.
 * Assumes status sources are levels from other clock domains and are
 * synchronised here; the register master never waits.
 */
`timescale 1ns/1ps
module qls_top (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [1:0] pair_aligned_i,
    input wire logic [1:0] pair_fail_i,
    input wire logic [1:0] pair_multi_i,
    input wire logic [1:0] pair_sm_en_i,
    input wire logic [3:0] link_up_i,
    input wire logic pll_lock_i,
    output logic [1:0] pair_aligned_o,
    output logic quad_irq_o
);
    // -------------------------------------------------------------
    // source synchronisation
    // -------------------------------------------------------------
    qls_pkg::qls_src_t src_raw;
    qls_pkg::qls_src_t src;
    qls_pkg::qls_bus_t bus;

    assign src_raw = '{pair_aligned: pair_aligned_i, pair_fail: pair_fail_i,
                       pair_multi: pair_multi_i, pair_sm_en: pair_sm_en_i,
                       link_up: link_up_i, pll_lock: pll_lock_i};
    assign bus = '{addr: addr_i, wr: wr_i, rd: rd_i};

    qls_sync #(
        .WIDTH($bits(qls_pkg::qls_src_t))
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .d_i(src_raw),
        .q_o(src)
    );

    // -------------------------------------------------------------
    // history of the synchronised levels for edge detection
    // -------------------------------------------------------------
    logic [1:0] pair_al_ff;
    logic [1:0] pair_fail_ff;
    logic [1:0] pair_multi_ff;
    logic [3:0] link_ff;
    logic pll_ff;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pair_al_ff <= qls_pkg::RST_PAIR;
            pair_fail_ff <= qls_pkg::RST_PAIR;
            pair_multi_ff <= qls_pkg::RST_PAIR;
            link_ff <= qls_pkg::RST_LINK;
            pll_ff <= 1'b0;
        end else begin
            pair_al_ff <= src.pair_aligned;
            pair_fail_ff <= src.pair_fail;
            pair_multi_ff <= src.pair_multi;
            link_ff <= src.link_up;
            pll_ff <= src.pll_lock;
        end
    end

    // -------------------------------------------------------------
    // event detection
    // -------------------------------------------------------------
    // pair events are masked while the link machine is off, since the
    // aligned status is meaningless then
    logic [1:0] pair_en;
    logic [1:0] pair_loss;
    logic [1:0] pair_gain;
    logic [1:0] pair_fail_rise;
    logic [1:0] pair_multi_rise;
    logic [3:0] sync_loss;
    logic [3:0] sync_gain;
    logic pll_gain;
    logic pll_loss;

    assign pair_en = src.pair_sm_en;
    assign pair_loss = pair_en & pair_al_ff & ~src.pair_aligned;
    assign pair_gain = pair_en & ~pair_al_ff & src.pair_aligned;
    assign pair_fail_rise = pair_en & ~pair_fail_ff & src.pair_fail;
    assign pair_multi_rise = pair_en & ~pair_multi_ff & src.pair_multi;
    assign sync_loss = link_ff & ~src.link_up;
    assign sync_gain = ~link_ff & src.link_up;
    assign pll_gain = ~pll_ff & src.pll_lock;
    assign pll_loss = pll_ff & ~src.pll_lock;

    // -------------------------------------------------------------
    // register decode
    // -------------------------------------------------------------
    logic rd_pair;
    logic rd_link;
    logic rd_sync;
    logic rd_pll;
    logic rd_pll_evt;

    assign rd_pair = bus.rd && (bus.addr == qls_pkg::ADDR_PAIR_EVT);
    assign rd_link = bus.rd && (bus.addr == qls_pkg::ADDR_LINK_STS);
    assign rd_sync = bus.rd && (bus.addr == qls_pkg::ADDR_SYNC_EVT);
    assign rd_pll = bus.rd && (bus.addr == qls_pkg::ADDR_PLL_STS);
    assign rd_pll_evt = bus.rd && (bus.addr == qls_pkg::ADDR_PLL_EVT);

    // -------------------------------------------------------------
    // sticky flags
    // -------------------------------------------------------------
    logic [7:0] pair_set;
    logic [7:0] sync_set;
    logic [7:0] pll_set;
    logic [7:0] pair_flags;
    logic [7:0] sync_flags;
    logic [7:0] pll_flags;
    logic [7:0] pll_sts_set;
    logic [7:0] pll_sts_flags;

    assign pair_set = {pair_multi_rise, pair_fail_rise, pair_gain, pair_loss};
    assign sync_set = {sync_gain, sync_loss};
    assign pll_set = {pll_loss, 2'h0, pll_gain, 4'h0};
    // the loss-of-lock status bit is itself sticky: a short dropout would
    // otherwise vanish before software looks
    assign pll_sts_set = {pll_loss, 7'h00};

    qls_flag #(
        .WIDTH(8)
    ) u_pair_flags (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .set_i(pair_set),
        .clr_i(rd_pair),
        .flag_o(pair_flags)
    );

    qls_flag #(
        .WIDTH(8)
    ) u_sync_flags (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .set_i(sync_set),
        .clr_i(rd_sync),
        .flag_o(sync_flags)
    );

    qls_flag #(
        .WIDTH(8)
    ) u_pll_flags (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .set_i(pll_set),
        .clr_i(rd_pll_evt),
        .flag_o(pll_flags)
    );

    qls_flag #(
        .WIDTH(8)
    ) u_pll_sts (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .set_i(pll_sts_set),
        .clr_i(rd_pll),
        .flag_o(pll_sts_flags)
    );

    // -------------------------------------------------------------
    // read data
    // -------------------------------------------------------------
    logic [7:0] link_word;
    logic [7:0] pll_word;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;

    assign link_word = {link_ff, ~link_ff};
    assign pll_word = {pll_sts_flags[qls_pkg::POS_PLL_LOSS], 2'h0,
                       pll_ff, 4'h0};

    always_comb begin
        nxt_rdata = qls_pkg::RD_RSVD;
        if (bus.rd) begin
            case (bus.addr)
                qls_pkg::ADDR_PAIR_EVT: nxt_rdata = pair_flags;
                qls_pkg::ADDR_LINK_STS: nxt_rdata = link_word;
                qls_pkg::ADDR_SYNC_EVT: nxt_rdata = sync_flags;
                qls_pkg::ADDR_PLL_STS: nxt_rdata = pll_word;
                qls_pkg::ADDR_PLL_EVT: nxt_rdata = pll_flags;
                default: nxt_rdata = qls_pkg::RD_RSVD;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_ff <= qls_pkg::RST_RDATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // writes are ignored: every register of this bank is read only
    logic unused_wr;
    assign unused_wr = bus.wr & (|wdata_i);

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    logic irq_ff;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (|pair_flags) | (|sync_flags) | (|pll_flags);
        end
    end

    assign rdata_o = rdata_ff;
    assign pair_aligned_o = pair_al_ff;
    assign quad_irq_o = irq_ff;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    pair_loss_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_loss[0] |=> pair_flags[qls_pkg::POS_PAIR_LOSS])
        else $error("pair loss flag not set");
    pair_loss_hi_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_loss[1] |=> pair_flags[qls_pkg::POS_PAIR_LOSS + 1])
        else $error("pair 23 loss flag not set");
    pair_gain_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_gain[1] |=> pair_flags[qls_pkg::POS_PAIR_GAIN + 1])
        else $error("pair gain flag not set");
    pair_gain_lo_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_gain[0] |=> pair_flags[qls_pkg::POS_PAIR_GAIN])
        else $error("pair 01 gain flag not set");
    pair_fail_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_fail_rise[0] |=> pair_flags[qls_pkg::POS_PAIR_FAIL])
        else $error("pair fail flag not set");
    pair_fail_hi_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_fail_rise[1] |=> pair_flags[qls_pkg::POS_PAIR_FAIL + 1])
        else $error("pair 23 fail flag not set");
    pair_multi_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_multi_rise[1] |=> pair_flags[7])
        else $error("multi alignment flag not set");
    pair_multi_lo_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_multi_rise[0] |=> pair_flags[qls_pkg::POS_PAIR_MULTI])
        else $error("pair 01 multi flag not set");
    link_word_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        rd_link |=> rdata_o == {$past(link_ff), ~$past(link_ff)})
        else $error("link status read wrong");
    sync_loss_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        sync_loss[2] |=> sync_flags[2])
        else $error("sync loss flag not set");
    sync_gain_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        sync_gain[3] |=> sync_flags[7])
        else $error("sync gain flag not set");
    pll_evt_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pll_loss |=> pll_flags[7] && pll_sts_flags[7])
        else $error("pll loss flags not set");
    pll_lock_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pll_gain |=> pll_flags[qls_pkg::POS_PLL_LOCK])
        else $error("pll lock flag not set");
    pll_live_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        rd_pll |=> rdata_o[qls_pkg::POS_PLL_LOCK] == $past(pll_ff))
        else $error("pll lock status read wrong");
    pll_sts_clr_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        rd_pll && !pll_loss |=> !pll_sts_flags[qls_pkg::POS_PLL_LOSS])
        else $error("loss of lock status not cleared");
    rsvd_read_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        bus.rd && (bus.addr == qls_pkg::ADDR_RSVD)
        |=> rdata_o == qls_pkg::RD_RSVD)
        else $error("reserved register not zero");
    pair_mask_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        !pair_en[0] && !(|(pair_flags & 8'h55)) |=> !(|(pair_flags & 8'h55)))
        else $error("pair 01 flag set while machine off");
    pair_mask_hi_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        !pair_en[1] && !(|(pair_flags & 8'hAA)) |=> !(|(pair_flags & 8'hAA)))
        else $error("pair 23 flag set while machine off");
    aligned_out_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        pair_aligned_o == $past(src.pair_aligned))
        else $error("aligned status output wrong");
    read_clear_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        rd_sync && !(|sync_set) |=> sync_flags == 8'h00)
        else $error("read did not clear flags");
    pair_clear_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        rd_pair && !(|pair_set) |=> pair_flags == 8'h00)
        else $error("read did not clear pair flags");
    pll_clear_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        rd_pll_evt && !(|pll_set) |=> pll_flags == 8'h00)
        else $error("read did not clear pll flags");
    set_wins_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        rd_sync && (|sync_set) |=> sync_flags == $past(sync_set))
        else $error("event lost in read cycle");
    flag_hold_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        !rd_sync |=> (sync_flags & $past(sync_flags)) == $past(sync_flags))
        else $error("flag dropped without a read");
    wr_ignore_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        unused_wr && !rd_sync && !(|sync_set) |=> $stable(sync_flags))
        else $error("write changed the flags");
    quad_sum_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        (|sync_flags) |=> quad_irq_o)
        else $error("summary bit missing");
    quad_pair_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        (|pair_flags) |=> quad_irq_o)
        else $error("summary bit missing for pair flags");
    quad_pll_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        (|pll_flags) |=> quad_irq_o)
        else $error("summary bit missing for pll flags");
    quad_idle_a: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        !(|pair_flags) && !(|sync_flags) && !(|pll_flags) |=> !quad_irq_o)
        else $error("summary bit set with no flag");
    for (genvar ch = 0; ch < 4; ch++) begin : g_chan_chk
        chan_loss_a: assert property (
            @(posedge mclk_i) disable iff (!rst_b_i)
            link_ff[ch] && !src.link_up[ch] |=>
            sync_flags[qls_pkg::POS_SYNC_LOSS + ch])
            else $error("channel sync loss flag not set");
        chan_gain_a: assert property (
            @(posedge mclk_i) disable iff (!rst_b_i)
            !link_ff[ch] && src.link_up[ch] |=>
            sync_flags[qls_pkg::POS_SYNC_GAIN + ch])
            else $error("channel sync gain flag not set");
        link_inv_a: assert property (
            @(posedge mclk_i) disable iff (!rst_b_i)
            rd_link |=> rdata_o[qls_pkg::POS_LINK_INV + ch] !=
            rdata_o[qls_pkg::POS_LINK_LIVE + ch])
            else $error("inverted link status wrong");
    end
endmodule

// >>> bench/qls_top_tb_top.sv
/*
 * Self-checking bench for the quad link status register bank.
 * Assumes the status inputs are slow levels and that a flag shows within
 * eight cycles of its cause; every read is one strobe cycle.
 */
`timescale 1ns/1ps
module qls_top_tb_top;

    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    localparam int CYC_LIMIT = 3000;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [1:0] pair_aligned_i = 2'h0;
    logic [1:0] pair_fail_i = 2'h0;
    logic [1:0] pair_multi_i = 2'h0;
    logic [1:0] pair_sm_en_i = 2'h0;
    logic [3:0] link_up_i = 4'h0;
    logic pll_lock_i = 1'b0;
    logic [1:0] pair_aligned_o;
    logic quad_irq_o;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 mclk_i = ~mclk_i;

    qls_top qls_top_inst (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .pair_aligned_i(pair_aligned_i),
        .pair_fail_i(pair_fail_i),
        .pair_multi_i(pair_multi_i),
        .pair_sm_en_i(pair_sm_en_i),
        .link_up_i(link_up_i),
        .pll_lock_i(pll_lock_i),
        .pair_aligned_o(pair_aligned_o),
        .quad_irq_o(quad_irq_o)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // read data are taken just after the edge that follows the strobe
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // two sync flops, history and flag stage fit well inside eight cycles
    task automatic settle();
        repeat (8) @(posedge mclk_i);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check({7'h00, quad_irq_o}, 8'h00);
        expect_reg(qls_pkg::ADDR_LINK_STS, 8'h0F);
        expect_reg(qls_pkg::ADDR_PAIR_EVT, 8'h00);
        expect_reg(qls_pkg::ADDR_SYNC_EVT, 8'h00);
        expect_reg(qls_pkg::ADDR_PLL_STS, 8'h00);
        expect_reg(qls_pkg::ADDR_PLL_EVT, 8'h00);
        expect_reg(qls_pkg::ADDR_RSVD, 8'h00);
        expect_reg(8'h00, 8'h00);
    endtask

    task automatic t_link();
        @(posedge mclk_i);
        link_up_i <= 4'hF;
        settle();
        check({7'h00, quad_irq_o}, 8'h01);
        expect_reg(qls_pkg::ADDR_LINK_STS, 8'hF0);
        // a write must not disturb the pending flags
        wr_reg(qls_pkg::ADDR_SYNC_EVT, 8'h00);
        expect_reg(qls_pkg::ADDR_SYNC_EVT, 8'hF0);
        @(posedge mclk_i);
        #1;
        check(rdata_o, 8'h00);
        expect_reg(qls_pkg::ADDR_SYNC_EVT, 8'h00);
        repeat (3) @(posedge mclk_i);
        check({7'h00, quad_irq_o}, 8'h00);
        link_up_i <= 4'h5;
        settle();
        expect_reg(qls_pkg::ADDR_SYNC_EVT, 8'h0A);
        expect_reg(qls_pkg::ADDR_LINK_STS, 8'h5A);
        wr_reg(qls_pkg::ADDR_SYNC_EVT, 8'hFF);
        expect_reg(qls_pkg::ADDR_SYNC_EVT, 8'h00);
    endtask

    task automatic t_pair();
        @(posedge mclk_i);
        pair_aligned_i <= 2'h3;
        settle();
        pair_aligned_i <= 2'h0;
        settle();
        expect_reg(qls_pkg::ADDR_PAIR_EVT, 8'h00);
        @(posedge mclk_i);
        pair_sm_en_i <= 2'h3;
        settle();
        pair_aligned_i <= 2'h3;
        settle();
        check({6'h00, pair_aligned_o}, 8'h03);
        expect_reg(qls_pkg::ADDR_PAIR_EVT, 8'h0C);
        @(posedge mclk_i);
        pair_aligned_i <= 2'h2;
        settle();
        check({6'h00, pair_aligned_o}, 8'h02);
        expect_reg(qls_pkg::ADDR_PAIR_EVT, 8'h01);
        @(posedge mclk_i);
        pair_fail_i <= 2'h3;
        pair_multi_i <= 2'h3;
        settle();
        check({7'h00, quad_irq_o}, 8'h01);
        expect_reg(qls_pkg::ADDR_PAIR_EVT, 8'hF0);
        expect_reg(qls_pkg::ADDR_PAIR_EVT, 8'h00);
        repeat (3) @(posedge mclk_i);
        check({7'h00, quad_irq_o}, 8'h00);
    endtask

    task automatic t_pll();
        @(posedge mclk_i);
        pll_lock_i <= 1'b1;
        settle();
        expect_reg(qls_pkg::ADDR_PLL_STS, 8'h10);
        expect_reg(qls_pkg::ADDR_PLL_EVT, 8'h10);
        expect_reg(qls_pkg::ADDR_PLL_EVT, 8'h00);
        @(posedge mclk_i);
        pll_lock_i <= 1'b0;
        settle();
        check({7'h00, quad_irq_o}, 8'h01);
        expect_reg(qls_pkg::ADDR_PLL_EVT, 8'h80);
        expect_reg(qls_pkg::ADDR_PLL_STS, 8'h80);
        expect_reg(qls_pkg::ADDR_PLL_STS, 8'h00);
        expect_reg(qls_pkg::ADDR_RSVD, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic results();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang in any wait ends the run as a failure
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == CYC_LIMIT) begin
            n_errors++;
            results();
        end
    end

    initial begin
        repeat (7) @(posedge mclk_i);
        #1;
        check(rdata_o, 8'h00);
        @(posedge mclk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_link();
        t_pair();
        t_pll();
        results();
    end

endmodule
